// ### shared/ubt_pkg.sv
package ubt_pkg;
    // register decode
    localparam logic [7:0] UBT_BUF_ADDR   = 8'h99;
    localparam logic [7:0] UBT_BUF_PAGE   = 8'h01;
    localparam logic [7:0] UBT_BUF_RESET  = 8'h00;
    localparam logic [7:0] UBT_UNMAPPED   = 8'h00;

    // baud timer clock selection
    localparam logic [1:0] UBT_PSC_DIV12  = 2'h0;
    localparam logic [1:0] UBT_PSC_DIV4   = 2'h1;
    localparam logic [1:0] UBT_PSC_DIV48  = 2'h2;
    localparam logic [1:0] UBT_PSC_EXT8   = 2'h3;
    localparam int         UBT_DIV12      = 12;
    localparam int         UBT_DIV4       = 4;
    localparam int         UBT_DIV48      = 48;
    localparam logic [2:0] UBT_EXT_LAST   = 3'h7;
    localparam logic [5:0] UBT_PSC_RESET  = 6'h00;
    localparam logic [7:0] UBT_TMR_RESET  = 8'h00;
    localparam logic [7:0] UBT_TMR_TOP    = 8'hFF;

    // frame lengths in bit times, start and stop included
    localparam logic [3:0] UBT_FRAME8     = 4'hA;
    localparam logic [3:0] UBT_FRAME9     = 4'hB;
    localparam logic [3:0] UBT_STOP_LEFT  = 4'h1;

    typedef enum logic [1:0] {
        UBT_TX_IDLE,
        UBT_TX_SHIFT
    } ubt_tx_e;

    typedef enum logic [1:0] {
        UBT_RX_IDLE,
        UBT_RX_START,
        UBT_RX_DATA
    } ubt_rx_e;
endpackage

// ### verilog/ubt_buf2.sv
`timescale 1ns/100ps
module ubt_buf2
    import ubt_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    if (DEPTH != 2) begin : g_chk
        $error("ubt_buf2 supports exactly two entries");
    end

    typedef struct packed {
        logic [W-1:0] e0;
        logic [W-1:0] e1;
        logic [1:0]   cnt;
    } ubt_buf_s;

    ubt_buf_s st_r;
    ubt_buf_s st_nxt;
    logic     push;
    logic     pop;

    assign in_ready  = (st_r.cnt != 2'h2);
    assign out_valid = (st_r.cnt != 2'h0);
    assign out_data  = st_r.e0;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        st_nxt = st_r;
        if (pop) begin
            st_nxt.e0 = st_r.e1;
        end
        if (push) begin
            // new word lands behind whatever survives the pop
            if ((st_r.cnt == 2'h0) || (st_r.cnt == 2'h1 && pop)) begin
                st_nxt.e0 = in_data;
            end else begin
                st_nxt.e1 = in_data;
            end
        end
        st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // ubt_buf2

// ### verilog/ubt_top.sv
`timescale 1ns/100ps
// Function
// - one buffer address: writes feed the transmitter, reads return the receive latch
// - writing the buffer alone starts transmission of that byte
// - reading the buffer returns the most recently accepted received byte
// - buffer sits at address 0x99 page 1, eight bits, resets to zero
// - timer clock: direct system clock, or divide 12, 4, 48, external/8
// - eight-bit auto-reload timer; bit time is two overflow periods
// - external/8 path counts rising external clock edges, used only when the direct system clock is not selected
// - baud rate is timer clock over 256 minus reload, halved
// - frame: start, eight data LSB first, optional ninth bit, stop
// - latch loads only if receive flag clear and checked bit passes
// - transmit flag set at stop start; flags sticky; either raises interrupt
module ubt_top
    import ubt_pkg::*;
#(
    parameter int TMR_W = 8
) (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_page,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    output logic            sfr_wr_ready,
    input  wire logic       frame_width_select,
    input  wire logic       multiproc_stop_check_enable,
    input  wire logic       receiver_enable,
    input  wire logic       transmit_ninth_bit,
    input  wire logic [1:0] timer_prescale_select,
    input  wire logic       timer_clock_direct_select,
    input  wire logic [7:0] baud_timer_reload_byte,
    input  wire logic       external_clock_input,
    input  wire logic       transmit_done_clear,
    input  wire logic       receive_done_clear,
    input  wire logic       port_irq_enable,
    output logic            transmit_done_flag,
    output logic            receive_done_flag,
    output logic            receive_ninth_bit,
    output logic            port_irq,
    output logic            serial_transmit_pin,
    input  wire logic       serial_receive_pin
);
    if (TMR_W != 8) begin : g_chk
        $error("ubt_top baud timer must be eight bits wide");
    end

    typedef struct packed {
        logic [5:0]  psc_cnt;
        logic        ext_prev;
        logic [2:0]  ext_cnt;
        logic [7:0]  tmr;
        ubt_tx_e     tx_st;
        logic [10:0] tx_sh;
        logic [3:0]  tx_bits;
        logic        tx_half;
        logic        tx_pin;
        logic        ti;
        ubt_rx_e     rx_st;
        logic [9:0]  rx_sh;
        logic [3:0]  rx_bits;
        logic        rx_half;
        logic [7:0]  latch;
        logic        rb8;
        logic        ri;
        logic [7:0]  rdata;
    } ubt_state_s;

    ubt_state_s st_r;
    ubt_state_s st_nxt;

    logic       buf_hit;
    logic       wr_hit;
    logic       txq_valid;
    logic       txq_ready;
    logic [7:0] txq_data;
    logic       tick;
    logic       ovf;

    // divide ratio minus one for the internal prescaler
    function automatic logic [5:0] psc_last(input logic [1:0] sel);
        case (sel)
            UBT_PSC_DIV4:  psc_last = 6'(UBT_DIV4 - 1);
            UBT_PSC_DIV48: psc_last = 6'(UBT_DIV48 - 1);
            default:       psc_last = 6'(UBT_DIV12 - 1);
        endcase
    endfunction

    assign buf_hit = (sfr_addr == UBT_BUF_ADDR) && (sfr_page == UBT_BUF_PAGE);
    assign wr_hit  = sfr_wr & buf_hit;

    // transmit bytes wait here while a frame is shifting
    ubt_buf2 #(
        .W     (8),
        .DEPTH (2)
    ) u_txq (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .in_valid  (wr_hit),
        .in_ready  (sfr_wr_ready),
        .in_data   (sfr_wdata),
        .out_valid (txq_valid),
        .out_ready (txq_ready),
        .out_data  (txq_data)
    );

    assign txq_ready = (st_r.tx_st == UBT_TX_IDLE);

    always_comb begin
        st_nxt = st_r;
        tick   = 1'b0;
        ovf    = 1'b0;

        // timer clock source
        st_nxt.ext_prev = external_clock_input;
        if (timer_clock_direct_select) begin
            tick = 1'b1;
        end else if (timer_prescale_select == UBT_PSC_EXT8) begin
            if (external_clock_input & ~st_r.ext_prev) begin
                st_nxt.ext_cnt = st_r.ext_cnt + 3'h1;
                tick           = (st_r.ext_cnt == UBT_EXT_LAST);
            end
        end else begin
            if (st_r.psc_cnt >= psc_last(timer_prescale_select)) begin
                st_nxt.psc_cnt = UBT_PSC_RESET;
                tick           = 1'b1;
            end else begin
                st_nxt.psc_cnt = st_r.psc_cnt + 6'h01;
            end
        end

        // auto-reload timer, one overflow per half bit
        if (tick) begin
            if (st_r.tmr == UBT_TMR_TOP) begin
                st_nxt.tmr = baud_timer_reload_byte;
                ovf        = 1'b1;
            end else begin
                st_nxt.tmr = st_r.tmr + 8'h01;
            end
        end

        // transmitter
        case (st_r.tx_st)
            UBT_TX_IDLE: begin
                if (txq_valid) begin
                    st_nxt.tx_st   = UBT_TX_SHIFT;
                    st_nxt.tx_sh   = {1'b1, frame_width_select ? transmit_ninth_bit : 1'b1,
                                      txq_data, 1'b0};
                    st_nxt.tx_bits = frame_width_select ? UBT_FRAME9 : UBT_FRAME8;
                    st_nxt.tx_half = 1'b0;
                    st_nxt.tx_pin  = 1'b0;
                end
            end
            UBT_TX_SHIFT: begin
                if (ovf) begin
                    st_nxt.tx_half = ~st_r.tx_half;
                    if (st_r.tx_half) begin
                        // two overflows make one bit time
                        if (st_r.tx_bits == UBT_STOP_LEFT) begin
                            st_nxt.tx_st  = UBT_TX_IDLE;
                            st_nxt.tx_pin = 1'b1;
                        end else begin
                            st_nxt.tx_sh   = {1'b1, st_r.tx_sh[10:1]};
                            st_nxt.tx_pin  = st_r.tx_sh[1];
                            st_nxt.tx_bits = st_r.tx_bits - 4'h1;
                        end
                    end
                end
            end
            default: begin
                st_nxt.tx_st  = UBT_TX_IDLE;
                st_nxt.tx_pin = 1'b1;
            end
        endcase
        // transmit flag: hardware set wins over a same-cycle clear
        st_nxt.ti = ((st_r.tx_st == UBT_TX_SHIFT) && ovf && st_r.tx_half &&
                     (st_r.tx_bits == UBT_STOP_LEFT + 4'h1)) |
                    (st_r.ti & ~transmit_done_clear);

        // receiver
        st_nxt.ri = st_r.ri & ~receive_done_clear;
        case (st_r.rx_st)
            UBT_RX_IDLE: begin
                if (receiver_enable && !serial_receive_pin) begin
                    st_nxt.rx_st = UBT_RX_START;
                end
            end
            UBT_RX_START: begin
                // first overflow lands within half a bit: check start is still low
                if (ovf) begin
                    st_nxt.rx_st   = serial_receive_pin ? UBT_RX_IDLE : UBT_RX_DATA;
                    st_nxt.rx_bits = (frame_width_select ? UBT_FRAME9 : UBT_FRAME8) - 4'h1;
                    st_nxt.rx_half = 1'b0;
                end
            end
            UBT_RX_DATA: begin
                if (ovf) begin
                    st_nxt.rx_half = ~st_r.rx_half;
                    if (st_r.rx_half) begin
                        st_nxt.rx_sh   = {serial_receive_pin, st_r.rx_sh[9:1]};
                        st_nxt.rx_bits = st_r.rx_bits - 4'h1;
                        if (st_r.rx_bits == UBT_STOP_LEFT) begin
                            st_nxt.rx_st = UBT_RX_IDLE;
                            // checked bit is the ninth bit, or the stop bit in 8-bit frames
                            if (!st_r.ri && (!multiproc_stop_check_enable ||
                                (frame_width_select ? st_nxt.rx_sh[8]
                                                    : serial_receive_pin))) begin
                                st_nxt.latch = frame_width_select ? st_nxt.rx_sh[7:0]
                                                                  : st_nxt.rx_sh[8:1];
                                st_nxt.rb8   = frame_width_select ? st_nxt.rx_sh[8]
                                                                  : serial_receive_pin;
                                st_nxt.ri    = 1'b1;
                            end
                        end
                    end
                end
            end
            default: st_nxt.rx_st = UBT_RX_IDLE;
        endcase
        if (!receiver_enable) begin
            st_nxt.rx_st = UBT_RX_IDLE;
        end

        // register read port
        if (sfr_rd) begin
            st_nxt.rdata = buf_hit ? st_r.latch : UBT_UNMAPPED;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r        <= '0;
            st_r.tx_st  <= UBT_TX_IDLE;
            st_r.rx_st  <= UBT_RX_IDLE;
            st_r.tx_pin <= 1'b1;
            // high, so a clock already high at release gives no false edge
            st_r.ext_prev <= 1'b1;
            st_r.tmr    <= UBT_TMR_RESET;
            st_r.latch  <= UBT_BUF_RESET;
            st_r.rdata  <= UBT_BUF_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sfr_rdata           = st_r.rdata;
    assign transmit_done_flag  = st_r.ti;
    assign receive_done_flag   = st_r.ri;
    assign receive_ninth_bit   = st_r.rb8;
    assign serial_transmit_pin = st_r.tx_pin;
    assign port_irq            = port_irq_enable & (st_r.ti | st_r.ri);
endmodule // ubt_top

// ### dv/ubt_top_checker.sv
`timescale 1ns/100ps
module ubt_top_checker
    import ubt_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       sfr_wr_ready,
    input wire logic       multiproc_stop_check_enable,
    input wire logic       transmit_done_clear,
    input wire logic       receive_done_clear,
    input wire logic       port_irq_enable,
    input wire logic       transmit_done_flag,
    input wire logic       receive_done_flag,
    input wire logic       receive_ninth_bit,
    input wire logic       port_irq,
    input wire logic       serial_transmit_pin
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_reset_state: assert property (disable iff (1'b0) sys_rst |=> sfr_rdata == 8'h00
        && serial_transmit_pin && !transmit_done_flag && !receive_done_flag && sfr_wr_ready)
        else $error("state after reset wrong");
    a_irq_level: assert property (port_irq == (port_irq_enable
        && (transmit_done_flag || receive_done_flag))) else $error("interrupt level wrong");
    a_tx_sticky: assert property (transmit_done_flag && !transmit_done_clear
        |=> transmit_done_flag) else $error("transmit flag dropped");
    a_rx_sticky: assert property (receive_done_flag && !receive_done_clear
        |=> receive_done_flag) else $error("receive flag dropped");
    a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    a_unmapped_rd: assert property (sfr_rd && (sfr_addr != UBT_BUF_ADDR
        || sfr_page != UBT_BUF_PAGE) |=> sfr_rdata == UBT_UNMAPPED)
        else $error("unmapped read not zero");
    a_stop_level: assert property ($rose(transmit_done_flag)
        |-> serial_transmit_pin ##1 serial_transmit_pin) else $error("flag not at stop bit");
    a_mp_check: assert property ($rose(receive_done_flag) && multiproc_stop_check_enable
        |-> receive_ninth_bit) else $error("checked bit low on accept");
endmodule // ubt_top_checker

bind ubt_top ubt_top_checker i_chk (.ref_clk, .sys_rst, .sfr_addr, .sfr_page, .sfr_rd,
    .sfr_rdata, .sfr_wr_ready, .multiproc_stop_check_enable, .transmit_done_clear,
    .receive_done_clear, .port_irq_enable, .transmit_done_flag, .receive_done_flag,
    .receive_ninth_bit, .port_irq, .serial_transmit_pin);

// ### dv/ubt_peer.sv
`timescale 1ns/100ps
module ubt_peer
(
    input wire logic ref_clk,
    input wire logic tx,
    output logic     rx
);
    initial rx = 1'b1;
    // start low, bits lsb first (stop included in w), then idle high
    task automatic send(input logic [9:0] w, input int n, input int bt);
        rx <= 1'b0;
        repeat (bt) @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            rx <= w[i];
            repeat (bt) @(posedge ref_clk);
        end
        rx <= 1'b1;
        repeat (bt) @(posedge ref_clk);
    endtask
    // first data bit must be 1: its rising edge marks an exact bit boundary
    task automatic grab(input int n, input int bt, output logic [9:0] w);
        w = '0;
        while (tx) @(posedge ref_clk);
        while (!tx) @(posedge ref_clk);
        w[0] = tx;
        repeat (bt / 2) @(posedge ref_clk);
        for (int i = 1; i < n; i++) begin
            repeat (bt) @(posedge ref_clk);
            w[i] = tx;
        end
    endtask
endmodule // ubt_peer

// ### dv/ubt_top_test.sv
`timescale 1ns/100ps
module ubt_top_test
    import ubt_pkg::*;
;
    logic       ref_clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic       frame_width_select = 1'b0, multiproc_stop_check_enable = 1'b0;
    logic       receiver_enable = 1'b1, transmit_ninth_bit = 1'b0, port_irq_enable = 1'b1;
    logic       timer_clock_direct_select = 1'b1, transmit_done_clear = 1'b0;
    logic       receive_done_clear = 1'b0, external_clock_input;
    logic [1:0] timer_prescale_select = 2'h0, ext_cnt = 2'h0;
    logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h01, sfr_wdata = 8'h00;
    logic [7:0] baud_timer_reload_byte = 8'hFE, sfr_rdata;
    logic       sfr_wr_ready, transmit_done_flag, receive_done_flag, receive_ninth_bit;
    logic       port_irq, serial_transmit_pin, serial_receive_pin;
    int         mismatches = 0, compares = 0, cyc = 0;
    // timer clock divisors; external path is 8 edges of a 4-cycle clock
    int         divs [4] = '{UBT_DIV12, UBT_DIV4, UBT_DIV48, 32};
    typedef struct packed {
        logic       dir;
        logic [1:0] psc;
        logic [7:0] rel;
        logic       nine;
        logic       tb8;
        logic [7:0] d;
    } ubt_row_s;
    ubt_row_s   rows [6] = '{
        '{1'b1, UBT_PSC_EXT8, 8'hFD, 1'b0, 1'b0, 8'hA5},
        '{1'b0, UBT_PSC_DIV12, 8'hFE, 1'b1, 1'b1, 8'h3B},
        '{1'b0, UBT_PSC_DIV4, 8'hFC, 1'b0, 1'b0, 8'h71},
        '{1'b0, UBT_PSC_DIV48, 8'hFE, 1'b1, 1'b0, 8'hC9},
        '{1'b0, UBT_PSC_EXT8, 8'hFE, 1'b0, 1'b0, 8'h5F},
        '{1'b0, UBT_PSC_DIV4, 8'hFF, 1'b1, 1'b1, 8'h81}};

    ubt_top i_dut (
        .ref_clk, .sys_rst, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .sfr_wr_ready, .frame_width_select, .multiproc_stop_check_enable, .receiver_enable,
        .transmit_ninth_bit, .timer_prescale_select, .timer_clock_direct_select,
        .baud_timer_reload_byte, .external_clock_input, .transmit_done_clear,
        .receive_done_clear, .port_irq_enable, .transmit_done_flag, .receive_done_flag,
        .receive_ninth_bit, .port_irq, .serial_transmit_pin, .serial_receive_pin);
    ubt_peer i_peer (.ref_clk, .tx(serial_transmit_pin), .rx(serial_receive_pin));

    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) ext_cnt <= ext_cnt + 2'h1;
    assign external_clock_input = ext_cnt[1];

    task automatic test_done();
        if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic chk(input string s, input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", s, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] v);
        @(posedge ref_clk);
        sfr_addr <= UBT_BUF_ADDR;
        sfr_wr <= 1'b1;
        sfr_wdata <= v;
        @(posedge ref_clk);
        while (!sfr_wr_ready) @(posedge ref_clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask
    task automatic clr();
        @(posedge ref_clk);
        transmit_done_clear <= 1'b1;
        receive_done_clear <= 1'b1;
        @(posedge ref_clk);
        transmit_done_clear <= 1'b0;
        receive_done_clear <= 1'b0;
    endtask

    initial begin
        logic [9:0] w, v, u;
        logic [7:0] d;
        int         bt, n;
        ubt_row_s   r;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(UBT_BUF_ADDR, d);
        chk("buffer reset", {2'b00, d}, {2'b00, UBT_BUF_RESET});
        foreach (rows[k]) begin
            r = rows[k];
            n = r.nine ? 10 : 9;
            bt = 2 * (256 - int'(r.rel)) * (r.dir ? 1 : divs[r.psc]);
            frame_width_select <= r.nine;
            transmit_ninth_bit <= r.tb8;
            timer_prescale_select <= r.psc;
            timer_clock_direct_select <= r.dir;
            baud_timer_reload_byte <= r.rel;
            v = r.nine ? {1'b1, r.tb8, r.d} : {2'b01, r.d};
            fork
                i_peer.grab(n, bt, w);
                wr(r.d);
            join
            chk("tx frame", w, v);
            chk("tx flag", {8'h0, port_irq, transmit_done_flag}, 10'h3);
            u = r.nine ? {1'b1, r.tb8, ~r.d} : {2'b01, ~r.d};
            i_peer.send(u, n, bt);
            rd(UBT_BUF_ADDR, d);
            v = {u[8], 1'b1, ~r.d};
            chk("rx byte", {receive_ninth_bit, receive_done_flag, d}, v);
            clr();
        end
        fork
            begin
                wr(8'h11);
                wr(8'h33);
                wr(8'h55);
                #1 chk("queue full", {9'h0, sfr_wr_ready}, 10'h0);
            end
            for (int j = 0; j < 3; j++) begin
                i_peer.grab(n, bt, w);
                chk("queued frame", w, {2'b11, 8'(8'h11 + 8'h22 * j)});
            end
        join
        clr();
        i_peer.send({2'b11, 8'hC3}, n, bt);
        i_peer.send({2'b11, 8'h3C}, n, bt);
        rd(UBT_BUF_ADDR, d);
        chk("overrun", {2'b11, d}, {2'b11, 8'hC3});
        clr();
        multiproc_stop_check_enable <= 1'b1;
        i_peer.send({2'b10, 8'h5A}, n, bt);
        chk("mp reject", {9'h0, receive_done_flag}, 10'h0);
        i_peer.send({2'b11, 8'h5A}, n, bt);
        rd(UBT_BUF_ADDR, d);
        chk("mp accept", {receive_done_flag, receive_ninth_bit, d}, {2'b11, 8'h5A});
        chk("irq on", {9'h0, port_irq}, 10'h1);
        @(posedge ref_clk);
        port_irq_enable <= 1'b0;
        sfr_page <= 8'h00;
        @(posedge ref_clk);
        chk("irq masked", {9'h0, port_irq}, 10'h0);
        // latch holds 5A here, so a page miss must read zero
        rd(UBT_BUF_ADDR, d);
        chk("wrong page rd", {2'b00, d}, 10'h0);
        wr(8'hFE);
        repeat (4) @(posedge ref_clk);
        chk("wrong page wr", {8'h0, sfr_wr_ready, serial_transmit_pin}, 10'h3);
        sfr_page <= UBT_BUF_PAGE;
        port_irq_enable <= 1'b1;
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(UBT_BUF_ADDR, d);
        chk("mid reset", {receive_done_flag, port_irq, d}, 10'h0);
        clr();
        receiver_enable <= 1'b0;
        i_peer.send({2'b11, 8'hE7}, n, bt);
        chk("rx off", {9'h0, receive_done_flag}, 10'h0);
        rd(8'h98, d);
        chk("unmapped rd", {2'b00, d}, 10'h0);
        test_done();
    end
endmodule // ubt_top_test
